/* File: logic/capture_unit_mode_control.sv */
// capture unit: mode control, capture path, compare outline, apb slave
`timescale 1ns/1ns
`default_nettype none
`include "capture_unit_cfg.svh"
// Operation
// - mode 0000 turns the unit off and clears only the prescale counter and output latch
// - 0101 captures every rising edge, 0100 every falling edge
// - 0110 captures every fourth rising edge, 0111 every sixteenth
// - a capture copies all sixteen timer bits into the value pair
// - every capture sets the capture interrupt flag
// - a new capture overwrites an unread stored value
// - pin should be input; driven output level changes can capture
// - changing capture mode may raise a spurious flag
// - prescale counter clears when off, not capturing, or reset
// - switching prescale settings directly keeps the counter
// - mode 1010 flags a timer match and leaves the pin alone
// - mode 1011 flags, clears timer, starts conversion, pin untouched
module capture_unit_mode_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [15:0] sixteen_bit_timer,
  input  wire logic        conversion_enabled,
  input  wire logic        unit_event_pin_in,
  output var  logic        unit_event_pin_out,
  output var  logic        unit_event_pin_oe_n,
  input  wire logic        port_latch_out,
  output var  logic        timer_clear,
  output var  logic        conversion_start,
  output var  capture_unit_pkg::control_s control_out,
  output var  logic        irq
);
  import capture_unit_pkg::*;

  logic [7:0]            control_reg;
  logic [15:0]           capture_value_reg;
  logic [7:0]            duty_high_byte_reg;
  logic [15:0]           compare_value_reg;
  logic [`IRQ_WIDTH-1:0] irq_status_reg;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg;
  logic                  pin_direction_bit_reg;
  logic                  compare_latch_reg;
  logic [3:0]            prescale_reg;
  logic [3:0]            prescale_next;
  logic                  pin_prev_reg;
  logic                  pin_level;
  logic                  pin_seen;
  logic [3:0]            mode;
  mode_kind_e            kind;
  logic                  rise_edge;
  logic                  fall_edge;
  logic                  capture_event;
  logic                  match;
  logic                  match_prev_reg;
  logic                  match_edge;
  compare_action_s       action;
  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_ok;
  logic [`IRQ_WIDTH-1:0] irq_set;

  assign mode = control_reg[3:0];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // no wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      `OFS_CONTROL, `OFS_CAPT_LOW, `OFS_CAPT_HIGH, `OFS_DUTY_HIGH,
      `OFS_COMPARE, `OFS_IRQ_STATUS, `OFS_IRQ_MASK,
      `OFS_PIN_DIR: addr_ok = 1'b1;
      default:      addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    case (mode[3:2])
      2'b00:   kind = (mode == `MODE_OFF) ? KIND_OFF : KIND_OFF;
      2'b01:   kind = KIND_CAPTURE;
      2'b10:   kind = KIND_COMPARE;
      2'b11:   kind = KIND_PWM;
      default: kind = KIND_OFF;
    endcase
  end

  // when the pin direction bit selects output, the port latch level is what is seen
  assign pin_seen = pin_direction_bit_reg ? pin_level : port_latch_out;

  pin_sync u_pin_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (unit_event_pin_in),
    .level_out (pin_level)
  );

  // previous level tracked in every mode, so a mode change cannot see an
  // old edge and raise a false flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_seen;
    end
  end

  assign rise_edge = pin_seen && !pin_prev_reg;
  assign fall_edge = !pin_seen && pin_prev_reg;

  always_comb begin
    prescale_next = prescale_reg;
    capture_event = 1'b0;
    case (mode)
      `MODE_CAPT_FALL: capture_event = fall_edge;
      `MODE_CAPT_RISE: capture_event = rise_edge;
      `MODE_CAPT_RISE4: begin
        if (rise_edge) begin
          capture_event = (prescale_reg[1:0] == 2'(`PRESCALE_4_LAST));
          prescale_next = prescale_reg + 4'h1;
        end
      end
      `MODE_CAPT_RISE16: begin
        if (rise_edge) begin
          capture_event = (prescale_reg == `PRESCALE_16_LAST);
          prescale_next = prescale_reg + 4'h1;
        end
      end
      default: prescale_next = prescale_reg;
    endcase
    if (kind != KIND_CAPTURE) begin
      prescale_next = 4'h0;
    end
  end

  // counter is kept across prescale switches, hence false events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_reg <= 16'h0000;
    end else if (capture_event) begin
      capture_value_reg <= sixteen_bit_timer;
    end else if (wr_en && paddr == `OFS_CAPT_LOW && kind != KIND_PWM) begin
      capture_value_reg[7:0] <= pwdata[7:0];
    end else if (wr_en && paddr == `OFS_CAPT_HIGH && kind != KIND_PWM) begin
      capture_value_reg[15:8] <= pwdata[7:0];
    end
  end

  assign match = (kind == KIND_COMPARE) &&
                 (sixteen_bit_timer == compare_value_reg);
  assign match_edge = match && !match_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_reg <= 1'b0;
    end else begin
      match_prev_reg <= match;
    end
  end

  always_comb begin
    action = '0;
    case (mode)
      `MODE_CMP_SET, `MODE_CMP_CLEAR: action.set_flag = match_edge;
      `MODE_CMP_SOFT:  action.set_flag = match_edge;
      `MODE_CMP_SPECIAL: begin
        action.set_flag         = match_edge;
        action.clear_timer      = match_edge;
        action.start_conversion = match_edge && conversion_enabled;
      end
      default: action = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_clear      <= 1'b0;
      conversion_start <= 1'b0;
    end else begin
      timer_clear      <= action.clear_timer;
      conversion_start <= action.start_conversion;
    end
  end

  // output latch falls back low whenever the unit is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_latch_reg <= 1'b0;
    end else if (kind == KIND_OFF) begin
      compare_latch_reg <= 1'b0;
    end else if (match_edge && mode == `MODE_CMP_SET) begin
      compare_latch_reg <= 1'b1;
    end else if (match_edge && mode == `MODE_CMP_CLEAR) begin
      compare_latch_reg <= 1'b0;
    end
  end

  // pin driven only in set/clear compare; soft and special leave it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_event_pin_out  <= 1'b0;
      unit_event_pin_oe_n <= 1'b1;
    end else begin
      unit_event_pin_out  <= compare_latch_reg;
      unit_event_pin_oe_n <= !(mode == `MODE_CMP_SET ||
                               mode == `MODE_CMP_CLEAR) ||
                             pin_direction_bit_reg;
    end
  end

  assign irq_set[`IRQ_CAPTURE_BIT] = capture_event;
  assign irq_set[`IRQ_COMPARE_BIT] = action.set_flag;

  // set beats a same-cycle software clear; hardware never clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_set |
        (irq_status_reg & ~((wr_en && paddr == `OFS_IRQ_STATUS) ?
          pwdata[`IRQ_WIDTH-1:0] : '0));
    end
  end

  // masking only gates the output; sticky status bits stay readable
  assign irq = |(irq_status_reg & irq_mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `CONTROL_RESET;
    end else if (wr_en && paddr == `OFS_CONTROL) begin
      control_reg <= pwdata[7:0] & `CONTROL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_high_byte_reg    <= 8'h00;
      compare_value_reg     <= 16'h0000;
      irq_mask_reg          <= '0;
      pin_direction_bit_reg <= 1'b1;
    end else if (wr_en) begin
      case (paddr)
        `OFS_DUTY_HIGH: duty_high_byte_reg <= pwdata[7:0];
        `OFS_COMPARE:   compare_value_reg <= pwdata[15:0];
        `OFS_IRQ_MASK:  irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
        `OFS_PIN_DIR:   pin_direction_bit_reg <= pwdata[0];
        default:        irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_out <= '0;
    end else begin
      control_out.duty_low_bits    <= control_reg[5:4];
      control_out.unit_mode_select <= control_reg[3:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        `OFS_CONTROL:    prdata = {24'h000000, control_reg};
        `OFS_CAPT_LOW:   prdata = {24'h000000, capture_value_reg[7:0]};
        `OFS_CAPT_HIGH:  prdata = {24'h000000, capture_value_reg[15:8]};
        `OFS_DUTY_HIGH:  prdata = {24'h000000, duty_high_byte_reg};
        `OFS_COMPARE:    prdata = {16'h0000, compare_value_reg};
        `OFS_IRQ_STATUS: prdata = {30'h0, irq_status_reg};
        `OFS_IRQ_MASK:   prdata = {30'h0, irq_mask_reg};
        `OFS_PIN_DIR:    prdata = {31'h0, pin_direction_bit_reg};
        default:         prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: logic/capture_unit_cfg.svh */
// register offsets, field positions, reset values and mode codes
`ifndef CAPTURE_UNIT_CFG_SVH
`define CAPTURE_UNIT_CFG_SVH
`define OFS_CONTROL      12'h000
`define OFS_CAPT_LOW     12'h004
`define OFS_CAPT_HIGH    12'h008
`define OFS_DUTY_HIGH    12'h00c
`define OFS_COMPARE      12'h010
`define OFS_IRQ_STATUS   12'h014
`define OFS_IRQ_MASK     12'h018
`define OFS_PIN_DIR      12'h01c
`define CONTROL_RESET    8'h00
`define CONTROL_WMASK    8'h3f
`define IRQ_CAPTURE_BIT  0
`define IRQ_COMPARE_BIT  1
`define IRQ_WIDTH        2
`define MODE_OFF         4'h0
`define MODE_CAPT_FALL   4'h4
`define MODE_CAPT_RISE   4'h5
`define MODE_CAPT_RISE4  4'h6
`define MODE_CAPT_RISE16 4'h7
`define MODE_CMP_SET     4'h8
`define MODE_CMP_CLEAR   4'h9
`define MODE_CMP_SOFT    4'ha
`define MODE_CMP_SPECIAL 4'hb
`define PRESCALE_4_LAST  4'h3
`define PRESCALE_16_LAST 4'hf
`endif

/* File: logic/capture_unit_pkg.sv */
// types shared by the capture unit files
package capture_unit_pkg;
  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } control_s;
  typedef struct packed {
    logic        set_flag;
    logic        clear_timer;
    logic        start_conversion;
  } compare_action_s;
  typedef enum logic [1:0] {
    KIND_OFF     = 2'b00,
    KIND_CAPTURE = 2'b01,
    KIND_COMPARE = 2'b10,
    KIND_PWM     = 2'b11
  } mode_kind_e;
endpackage

/* File: logic/pin_sync.sv */
// three-stage synchroniser with agreement filter for the event pin
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // level only moves once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= 1'b0;
    end else if (stage2_reg == stage3_reg) begin
      level_out <= stage3_reg;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/capture_unit_mode_control_asserts.sv */
// port checker for the capture unit
`timescale 1ns/1ns
`default_nettype none
module capture_unit_checks (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        timer_clear,
  input wire logic                        conversion_start,
  input wire logic                        unit_event_pin_oe_n,
  input wire logic                        irq,
  input wire capture_unit_pkg::control_s  control_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       acc;
  logic       wr;
  logic [3:0] md;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign md = control_out.unit_mode_select;
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_unmapped;
    acc && paddr > 12'h01c |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
  property p_ctl_rd;
    acc && !pwrite && paddr == 12'h000 |-> prdata[31:6] == 26'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("ctl high bits");
  property p_off;
    md == 4'h0 [*2] |-> unit_event_pin_oe_n && !timer_clear;
  endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_drive;
    !unit_event_pin_oe_n |-> md inside {4'h8, 4'h9}
      || $past(md) inside {4'h8, 4'h9};
  endproperty
  a_drive: assert property (p_drive) else $error("pin on");
  property p_clr;
    timer_clear |-> (md == 4'hb || $past(md) == 4'hb) ##1 !timer_clear;
  endproperty
  a_clr: assert property (p_clr) else $error("timer clear");
  property p_conv; conversion_start |-> timer_clear; endproperty
  a_conv: assert property (p_conv) else $error("conversion");
  property p_irq_hold; $fell(irq) |-> $past(wr); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell");
  c_irq: cover property ($rose(irq));
  c_clr: cover property (timer_clear);
  c_drv: cover property (!unit_event_pin_oe_n);
endmodule
bind capture_unit_mode_control capture_unit_checks u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .timer_clear,
  .conversion_start, .unit_event_pin_oe_n, .irq, .control_out);
`default_nettype wire

/* File: testbench/event_source.sv */
// external event source: bursts of 8-high 8-low pulses
`timescale 1ns/1ns
`default_nettype none
module event_source (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       start,
  input wire logic [4:0] count,
  output var logic       pin,
  output var logic       busy
);
  logic [4:0] left;
  logic [3:0] ph;
  // pin idles low; the port_flag test makes its edge from the port latch instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
      busy <= 1'b0;
      left <= 5'h0;
      ph <= 4'h0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      left <= count;
      ph <= 4'h0;
    end else if (busy) begin
      ph <= ph + 4'h1;
      if (ph == 4'h7) pin <= 1'b1;
      if (ph == 4'hf) begin
        pin <= 1'b0;
        left <= left - 5'h1;
        if (left == 5'h1) busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_capture_unit_mode_control.sv */
// self-checking bench for the capture unit
`timescale 1ns/1ns
`default_nettype none
`include "capture_unit_cfg.svh"
module test_capture_unit_mode_control;
  import capture_unit_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] timer, t;
  logic        pin, pin_out, oe_n, tclr, cst, irq, run, go, busy;
  logic        clr_seen, conv_seen;
  logic        conv_en, latch;
  logic [4:0]  cnt;
  logic [7:0]  c [2];
  control_s    ctl;
  int          bad_count, checked, n;
  capture_unit_mode_control DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sixteen_bit_timer(timer),
    .conversion_enabled(conv_en), .unit_event_pin_in(pin),
    .unit_event_pin_out(pin_out), .unit_event_pin_oe_n(oe_n),
    .port_latch_out(latch), .timer_clear(tclr), .conversion_start(cst),
    .control_out(ctl), .irq);
  event_source SRC (.pclk, .presetn, .start(go), .count(cnt), .pin, .busy);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (run) timer <= timer + 16'h1;
    if (tclr) clr_seen <= 1'b1;
    if (cst) conv_seen <= 1'b1;
  end
  function automatic logic [1:0] pin_exp(input int m);
    return m == 8 ? 2'b01 : m == 9 ? 2'b00 : 2'b10;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdv = prdata;
    slv = pslverr;
    if (k >= 16) begin
      bad_count++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input int e, input string nm);
    apb(1'b0, a, 0);
    chk(nm, rdv, e);
  endtask
  task automatic irqchk(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask
  task automatic pulses(input int p);
    int k;
    @(posedge pclk);
    go <= 1'b1;
    cnt <= 5'(p);
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    for (k = 0; busy && k < 600; k++) @(posedge pclk);
    if (k >= 600) begin
      bad_count++;
      tally_and_finish();
    end
    repeat (12) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run, go, cnt} = '0;
    {timer, clr_seen, conv_seen, conv_en, latch, bad_count, checked} = '0;
    void'($urandom(97));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_CONTROL, 0, "control");
    rd(`OFS_PIN_DIR, 1, "pin_dir");
    rd(`OFS_IRQ_STATUS, 0, "status");
    rd(12'h020, 0, "unmapped");
    chk("slverr", {31'h0, slv}, 1);
    wr(`OFS_CONTROL, 'hff);
    rd(`OFS_CONTROL, 'h3f, "ctl_bits");
    chk("ctl_out", {26'h0, ctl}, 'h3f);
    wr(`OFS_IRQ_MASK, 1);
    for (int m = 4; m < 6; m++) begin
      wr(`OFS_CONTROL, 0);
      wr(`OFS_CONTROL, m);
      wr(`OFS_IRQ_STATUS, 3);
      repeat (2) begin
        t = 16'($urandom);
        timer <= t;
        pulses(1);
      end
      rd(`OFS_CAPT_LOW, t[7:0], "capt_lo");
      rd(`OFS_CAPT_HIGH, t[15:8], "capt_hi");
      rd(`OFS_IRQ_STATUS, 1, "flag");
      irqchk(1'b1);
      timer <= 16'h0;
      run <= 1'b1;
      pulses(1);
      run <= 1'b0;
      apb(1'b0, `OFS_CAPT_LOW, 0);
      c[m-4] = rdv[7:0];
    end
    chk("edge_gap", 32'(c[0] - c[1]), 8);
    wr(`OFS_IRQ_MASK, 0);
    irqchk(1'b0);
    wr(`OFS_IRQ_MASK, 1);
    irqchk(1'b1);
    wr(`OFS_IRQ_STATUS, 1);
    irqchk(1'b0);
    for (int i = 0; i < 2; i++) begin
      n = i ? 16 : 4;
      wr(`OFS_CONTROL, 0);
      wr(`OFS_CONTROL, 6 + i);
      pulses(2);
      wr(`OFS_CONTROL, 0);
      wr(`OFS_CONTROL, 6 + i);
      wr(`OFS_IRQ_STATUS, 3);
      pulses(n - 1);
      rd(`OFS_IRQ_STATUS, 0, "pre_early");
      t = 16'($urandom);
      timer <= t;
      pulses(1);
      rd(`OFS_IRQ_STATUS, 1, "pre_hit");
      rd(`OFS_CAPT_LOW, t[7:0], "pre_val");
    end
    wr(`OFS_CONTROL, 0);
    wr(`OFS_CONTROL, `MODE_CAPT_RISE);
    wr(`OFS_PIN_DIR, 0);
    wr(`OFS_IRQ_STATUS, 3);
    t = 16'($urandom);
    timer <= t;
    latch <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(`OFS_IRQ_STATUS, 1, "port_flag");
    rd(`OFS_CAPT_HIGH, t[15:8], "port_val");
    for (int m = 8; m < 13; m++) begin
      t = 16'($urandom) & 16'h7fff;
      timer <= t;
      conv_en <= (m != 12);
      wr(`OFS_CONTROL, 0);
      wr(`OFS_COMPARE, t + 16'd20);
      wr(`OFS_IRQ_STATUS, 3);
      clr_seen <= 1'b0;
      conv_seen <= 1'b0;
      wr(`OFS_CONTROL, m > 11 ? 11 : m);
      run <= 1'b1;
      repeat (40) @(posedge pclk);
      run <= 1'b0;
      rd(`OFS_IRQ_STATUS, 2, "cmp_flag");
      chk("pin", {oe_n, pin_out}, pin_exp(m));
      n = m < 11 ? 0 : m == 11 ? 3 : 2;
      chk("clear", {clr_seen, conv_seen}, n);
    end
    wr(`OFS_CONTROL, 0);
    repeat (2) @(posedge pclk);
    chk("off_pin", {oe_n, pin_out}, pin_exp(0));
    tally_and_finish();
  end
endmodule
`default_nettype wire
